// ---- logic/sbcms_pkg.sv ----
// Package of constants and types for the operating-mode sequencer and configuration capture
`default_nettype none
package sbcms_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_PERIOD_PS      = 4000;
	// Filter time of the configuration pin, least time, rounded up
	localparam int CFG_FILTER_TIME_NS = 2000;
	localparam int CFG_FILTER_CYCLES  = (CFG_FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Reset delay time, least time, rounded up; above 4096 cycles, so the top exposes it
	localparam int RESET_DELAY_TIME_NS = 10000000;
	// Divide first: the nanosecond figure times 1000 would overflow a 32-bit int
	localparam int RESET_DELAY_CYCLES  = RESET_DELAY_TIME_NS / (CLK_PERIOD_PS / 1000);
	localparam logic [4:0]  FILT_LAST  = 5'(0);

	// ****************************************
	// Operating modes, Gray coded along Init-Normal-Stop-Sleep-Restart-FailSafe
	// ****************************************
	typedef enum logic [2:0] {
		SBCMS_INIT      = 3'h0,
		SBCMS_NORMAL    = 3'h1,
		SBCMS_STOP      = 3'h3,
		SBCMS_SLEEP     = 3'h2,
		SBCMS_RESTART   = 3'h6,
		SBCMS_FAILSAFE  = 3'h7
	} sbcms_mode_e;

	// Requests written into the mode field
	localparam logic [1:0] MREQ_NORMAL  = 2'h0;
	localparam logic [1:0] MREQ_SLEEP   = 2'h1;
	localparam logic [1:0] MREQ_STOP    = 2'h2;
	localparam logic [1:0] MREQ_SOFTRST = 2'h3;

	// ****************************************
	// Register map (byte addresses, 32-bit words, data in low bits)
	// ****************************************
	localparam logic [7:0] ADR_MODE_CTRL = 8'h00;
	localparam logic [7:0] ADR_HW_CTRL   = 8'h04;
	localparam logic [7:0] ADR_STATUS    = 8'h08;
	localparam logic [7:0] ADR_FLAGS     = 8'h0C;

	// Mode control
	localparam int MODE_FLD_LSB = 0;
	localparam int MODE_FLD_MSB = 1;
	// Hardware control
	localparam int HW_CFG_SEL_BIT  = 0;
	localparam int HW_OV_RST_BIT   = 1;
	localparam int HW_AUX_ON_BIT   = 2;
	localparam int HW_LOCK_BIT     = 3;
	localparam logic HW_CFG_SEL_RST = 1'b0;
	// Status
	localparam int ST_MODE_LSB     = 0;
	localparam int ST_MODE_MSB     = 2;
	localparam int ST_DEV_BIT      = 3;
	localparam int ST_CFGPIN_BIT   = 4;
	localparam int ST_FAIL_BIT     = 5;
	localparam int ST_RSTOUT_BIT   = 6;
	// Flags, write one to clear
	localparam int FL_POR_BIT      = 0;
	localparam int FL_SUPPLY_LSB   = 1;
	localparam int FL_WDFAIL_BIT   = 4;
	localparam int N_SUPPLY_FLAGS  = 3;

endpackage
`default_nettype wire

// ---- logic/sbcms_top.sv ----
// Operating-mode state machine and power-up hardware configuration capture
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module sbcms_top
	import sbcms_pkg::*;
#(
	parameter int RD_CYCLES = RESET_DELAY_CYCLES
) (
	// Clock and power-on reset
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Supervision inputs
	input  wire logic        main_supply_undervolt_i,
	input  wire logic        main_supply_warning_i,
	input  wire logic        battery_undervolt_i,
	input  wire logic        overvolt_i,
	input  wire logic        overtemp_i,
	input  wire logic        wd_fail_i,
	// Wake sources
	input  wire logic        can_wake_i,
	input  wire logic        wake_sense_input_i,
	input  wire logic        gpio_wake_i,
	// Configuration pins
	input  wire logic        test_pin_i,
	input  wire logic        interrupt_config_pin_i,
	output logic             interrupt_config_pin_pd_o,
	// Controls to the device
	output logic             reset_output_low_active_o,
	output logic             main_regulator_output_en_o,
	output logic             aux_regulator_output_en_o,
	output logic             can_force_normal_o,
	output logic             wd_long_window_start_o,
	output logic             wd_halt_o,
	output logic             fail_output_o,
	output logic [2:0]       mode_o,
	output logic             config_pin_state_o
);

	// ****************************************
	// Declarations
	// ****************************************
	sbcms_mode_e mode_r, mode_nxt;
	logic [1:0]  mode_fld_r;
	logic        cfg_sel_r, ov_rst_r, aux_on_r, lock_r;
	logic        por_flag_r, wdfail_flag_r;
	logic [N_SUPPLY_FLAGS-1:0] supply_flag_r;
	logic [N_SUPPLY_FLAGS-1:0] supply_in;
	logic        reset_output_low_active_r, released_once_r, dev_r, first_fail_r, ot_seen_r;
	logic [31:0] rd_cnt_r;
	logic        rd_done, rel_now;
	logic [15:0] filt_cnt_r;
	logic        pin_prev_r, filt_val_r, filt_valid_r, cfg_state_r;
	logic        pd_r, lw_start_r, fo_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic        acc, wr, wr_mode, wr_hw, wr_flags, soft_rst;
	logic        wake_any, wd_evt, ov_evt, uv_evt, fault_restart, fault_failsafe;

	// Mode in which the watchdog, supply and overvoltage supervision react
	function automatic logic supervised(input sbcms_mode_e m);
		return (m == SBCMS_INIT) || (m == SBCMS_NORMAL) || (m == SBCMS_STOP);
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	// One access equals one 32-bit register word; taken at the edge that raises ack
	assign acc      = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr       = acc && wb_we_i && wb_sel_i[0];
	assign wr_mode  = wr && (wb_adr_i == ADR_MODE_CTRL);
	assign wr_hw    = wr && (wb_adr_i == ADR_HW_CTRL);
	assign wr_flags = wr && (wb_adr_i == ADR_FLAGS);
	assign soft_rst = wr_mode && (wb_dat_i[MODE_FLD_MSB:MODE_FLD_LSB] == MREQ_SOFTRST);

	// ****************************************
	// Event decode
	// ****************************************
	assign wake_any = can_wake_i || wake_sense_input_i || gpio_wake_i;
	// Watchdog failures count only once the reset output has gone high
	assign wd_evt   = wd_fail_i && !dev_r && reset_output_low_active_r && supervised(mode_r);
	assign ov_evt   = overvolt_i && ov_rst_r && reset_output_low_active_r && supervised(mode_r);
	// Undervoltage restarts only after the first release at power-up
	assign uv_evt   = main_supply_undervolt_i && released_once_r && reset_output_low_active_r && supervised(mode_r);
	// With pin state zero, a failure with select one, the second failure with select zero, or an overvoltage reset ends in Fail-Safe
	assign fault_failsafe = (wd_evt && !cfg_state_r && (cfg_sel_r || first_fail_r)) ||
	                        (ov_evt && !cfg_state_r);
	assign fault_restart  = (wd_evt || ov_evt || uv_evt) && !fault_failsafe;

	// ****************************************
	// Reset delay
	// ****************************************
	assign rd_done = (rd_cnt_r >= 32'(RD_CYCLES));
	// Release only while the supply is above its threshold and no overtemperature forces Fail-Safe
	assign rel_now = !reset_output_low_active_r && rd_done && !main_supply_undervolt_i && !overtemp_i &&
	                 ((mode_r == SBCMS_INIT) || (mode_r == SBCMS_RESTART));

	// Counter restarts whenever the reset output is high or the supply dips
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_cnt_r <= 32'h0000_0000;
		end else if (reset_output_low_active_r || main_supply_undervolt_i ||
		             (mode_r != SBCMS_INIT && mode_r != SBCMS_RESTART)) begin
			rd_cnt_r <= 32'h0000_0000;
		end else if (!rd_done) begin
			rd_cnt_r <= rd_cnt_r + 32'h0000_0001;
		end
	end

	// ****************************************
	// Mode machine
	// ****************************************
	// Priority: fault, then wake, then host request
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			SBCMS_INIT: begin
				// Wake events are ignored here
				if (fault_failsafe || overtemp_i) begin
					mode_nxt = SBCMS_FAILSAFE;
				end else if (fault_restart) begin
					mode_nxt = SBCMS_RESTART;
				end else if (acc && !soft_rst) begin
					mode_nxt = SBCMS_NORMAL;
				end
			end
			SBCMS_NORMAL, SBCMS_STOP: begin
				if (fault_failsafe || overtemp_i) begin
					mode_nxt = SBCMS_FAILSAFE;
				end else if (fault_restart) begin
					mode_nxt = SBCMS_RESTART;
				end else if (soft_rst) begin
					mode_nxt = SBCMS_INIT;
				end else if (wr_mode) begin
					unique case (wb_dat_i[MODE_FLD_MSB:MODE_FLD_LSB])
						MREQ_NORMAL: mode_nxt = SBCMS_NORMAL;
						MREQ_SLEEP:  mode_nxt = SBCMS_SLEEP;
						MREQ_STOP:   mode_nxt = SBCMS_STOP;
						MREQ_SOFTRST: mode_nxt = SBCMS_INIT;
					endcase
				end
			end
			SBCMS_SLEEP: begin
				if (wake_any) begin
					mode_nxt = SBCMS_RESTART;
				end
			end
			SBCMS_RESTART: begin
				if (overtemp_i) begin
					mode_nxt = SBCMS_FAILSAFE;
				end else if (rel_now) begin
					mode_nxt = SBCMS_NORMAL;
				end
			end
			SBCMS_FAILSAFE: begin
				if (wake_any || (ot_seen_r && !overtemp_i)) begin
					mode_nxt = SBCMS_RESTART;
				end
			end
			default: mode_nxt = SBCMS_INIT;
		endcase
	end

	// Single state register keeps the modes exclusive
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_r <= SBCMS_INIT;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// Overtemperature entry is remembered so its clearing can end Fail-Safe
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ot_seen_r <= 1'b0;
		end else if (mode_r != SBCMS_FAILSAFE) begin
			ot_seen_r <= overtemp_i;
		end else if (overtemp_i) begin
			ot_seen_r <= 1'b1;
		end
	end

	// ****************************************
	// Reset output and watchdog start
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reset_output_low_active_r          <= 1'b0;
			released_once_r <= 1'b0;
			lw_start_r      <= 1'b0;
		end else begin
			lw_start_r <= rel_now;
			if (rel_now) begin
				reset_output_low_active_r          <= 1'b1;
				released_once_r <= 1'b1;
			end else if (mode_nxt == SBCMS_RESTART || mode_nxt == SBCMS_FAILSAFE ||
			             mode_nxt == SBCMS_SLEEP) begin
				reset_output_low_active_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Configuration pin capture
	// ****************************************
	// Weak pull-down while reset is held and the power-on flag is still set
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pd_r <= 1'b0;
		end else begin
			pd_r <= por_flag_r && !reset_output_low_active_r && !rel_now;
		end
	end

	// Continuous filter: a level counts once stable for the whole filter time
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_prev_r   <= 1'b0;
			filt_cnt_r   <= 16'h0000;
			filt_val_r   <= 1'b0;
			filt_valid_r <= 1'b0;
		end else begin
			pin_prev_r <= interrupt_config_pin_i;
			if (interrupt_config_pin_i != pin_prev_r) begin
				filt_cnt_r <= 16'h0000;
			end else if (filt_cnt_r < 16'(CFG_FILTER_CYCLES - 1)) begin
				filt_cnt_r <= filt_cnt_r + 16'h0001;
			end else begin
				filt_val_r   <= interrupt_config_pin_i;
				filt_valid_r <= 1'b1;
			end
		end
	end

	// Latched only at reset release with the power-on flag set, held otherwise
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_state_r <= 1'b0;
		end else if (rel_now && por_flag_r) begin
			cfg_state_r <= filt_valid_r ? filt_val_r : 1'b0;
		end
	end

	// Development mode follows the test pin only while in Init
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dev_r <= 1'b0;
		end else if (mode_r == SBCMS_INIT) begin
			dev_r <= test_pin_i;
		end
	end

	// ****************************************
	// Watchdog failure bookkeeping
	// ****************************************
	// Fail output on first failure with select one, on second with select zero
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			first_fail_r <= 1'b0;
			fo_r         <= 1'b0;
		end else begin
			if (wd_evt) begin
				first_fail_r <= 1'b1;
			end else if (soft_rst) begin
				first_fail_r <= 1'b0;
			end
			// Set wins over the software clear
			if ((wd_evt && (cfg_sel_r || first_fail_r)) || ov_evt) begin
				fo_r <= 1'b1;
			end else if (wr_flags && wb_dat_i[FL_WDFAIL_BIT]) begin
				fo_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// Mode field holds the last written request that changed the mode, cleared through Restart
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_fld_r <= MREQ_NORMAL;
		end else if (mode_nxt == SBCMS_RESTART || soft_rst) begin
			mode_fld_r <= MREQ_NORMAL;
		end else if (wr_mode && mode_nxt != mode_r) begin
			mode_fld_r <= wb_dat_i[MODE_FLD_MSB:MODE_FLD_LSB];
		end
	end

	// Soft reset restores these, the lock bit and the locked select bit excepted
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_sel_r <= HW_CFG_SEL_RST;
			ov_rst_r  <= 1'b0;
			aux_on_r  <= 1'b0;
			lock_r    <= 1'b0;
		end else if (soft_rst) begin
			if (!lock_r) begin
				cfg_sel_r <= HW_CFG_SEL_RST;
			end
			ov_rst_r <= 1'b0;
			aux_on_r <= 1'b0;
		end else if (wr_hw) begin
			if (!lock_r) begin
				cfg_sel_r <= wb_dat_i[HW_CFG_SEL_BIT];
			end
			ov_rst_r <= wb_dat_i[HW_OV_RST_BIT];
			aux_on_r <= wb_dat_i[HW_AUX_ON_BIT];
			// Lock can only be set; it stays until power is lost
			lock_r   <= lock_r || wb_dat_i[HW_LOCK_BIT];
		end
	end

	// ****************************************
	// Flags
	// ****************************************
	// Power-on flag set by reset, cleared by the host
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			por_flag_r <= 1'b1;
		end else if (wr_flags && wb_dat_i[FL_POR_BIT]) begin
			por_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wdfail_flag_r <= 1'b0;
		end else if (wd_evt) begin
			wdfail_flag_r <= 1'b1;
		end else if (wr_flags && wb_dat_i[FL_WDFAIL_BIT]) begin
			wdfail_flag_r <= 1'b0;
		end
	end

	assign supply_in = {battery_undervolt_i, main_supply_undervolt_i, main_supply_warning_i};

	// Supply flags cannot set until the first release, though the host can clear them before it; set beats clear
	generate
		for (genvar g = 0; g < N_SUPPLY_FLAGS; g++) begin : g_supply
			always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					supply_flag_r[g] <= 1'b0;
				end else if (released_once_r && supply_in[g]) begin
					supply_flag_r[g] <= 1'b1;
				end else if (wr_flags && wb_dat_i[FL_SUPPLY_LSB + g]) begin
					supply_flag_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// Bus answer
	// ****************************************
	// Ack one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= acc;
			dat_r <= 32'h0000_0000;
			if (acc) begin
				unique case (wb_adr_i)
					ADR_MODE_CTRL: dat_r[MODE_FLD_MSB:MODE_FLD_LSB] <= mode_fld_r;
					ADR_HW_CTRL: begin
						dat_r[HW_CFG_SEL_BIT] <= cfg_sel_r;
						dat_r[HW_OV_RST_BIT]  <= ov_rst_r;
						dat_r[HW_AUX_ON_BIT]  <= aux_on_r;
						dat_r[HW_LOCK_BIT]    <= lock_r;
					end
					ADR_STATUS: begin
						dat_r[ST_MODE_MSB:ST_MODE_LSB] <= mode_r;
						dat_r[ST_DEV_BIT]    <= dev_r;
						dat_r[ST_CFGPIN_BIT] <= cfg_state_r;
						dat_r[ST_FAIL_BIT]   <= fo_r;
						dat_r[ST_RSTOUT_BIT] <= reset_output_low_active_r;
					end
					ADR_FLAGS: begin
						dat_r[FL_POR_BIT]    <= por_flag_r;
						dat_r[FL_SUPPLY_LSB +: N_SUPPLY_FLAGS] <= supply_flag_r;
						dat_r[FL_WDFAIL_BIT] <= wdfail_flag_r;
					end
					default: dat_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// Output registers
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			main_regulator_output_en_o <= 1'b1;
			aux_regulator_output_en_o  <= 1'b0;
			can_force_normal_o         <= 1'b0;
			wd_halt_o                  <= 1'b0;
		end else begin
			// Off in Sleep and Fail-Safe, kept on in Stop
			main_regulator_output_en_o <= (mode_nxt != SBCMS_SLEEP) && (mode_nxt != SBCMS_FAILSAFE);
			aux_regulator_output_en_o  <= aux_on_r || dev_r;
			can_force_normal_o         <= dev_r;
			wd_halt_o                  <= dev_r;
		end
	end

	assign wb_ack_o                  = ack_r;
	assign wb_dat_o                  = dat_r;
	assign interrupt_config_pin_pd_o = pd_r;
	assign reset_output_low_active_o = reset_output_low_active_r;
	assign wd_long_window_start_o    = lw_start_r;
	assign fail_output_o             = fo_r;
	assign mode_o                    = mode_r;
	assign config_pin_state_o        = cfg_state_r;

endmodule
`default_nettype wire

// ---- dv/sbcms_top_asserts.sv ----
// Port checker for the mode sequencer and configuration capture
`timescale 1ns/1ps
`default_nettype none
module sbcms_top_asserts
	import sbcms_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       arst_n_i,
	// Watched outputs
	input wire logic       wb_ack_o,
	input wire logic [2:0] mode_o,
	input wire logic       main_regulator_output_en_o,
	input wire logic       reset_output_low_active_o,
	input wire logic       wd_long_window_start_o,
	input wire logic       wd_halt_o,
	input wire logic       can_force_normal_o,
	input wire logic       aux_regulator_output_en_o,
	input wire logic       interrupt_config_pin_pd_o,
	input wire logic       config_pin_state_o
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_wd_start; $rose(reset_output_low_active_o) |-> wd_long_window_start_o; endproperty
	a_wd_start: assert property (p_wd_start) else $error("no long window start");
	property p_stop_reg; mode_o == SBCMS_STOP |-> main_regulator_output_en_o; endproperty
	a_stop_reg: assert property (p_stop_reg) else $error("regulator off in stop");
	property p_sleep_reg; mode_o == SBCMS_SLEEP |-> !main_regulator_output_en_o; endproperty
	a_sleep_reg: assert property (p_sleep_reg) else $error("regulator on in sleep");
	property p_fs_off; mode_o == SBCMS_FAILSAFE |-> !main_regulator_output_en_o && !reset_output_low_active_o; endproperty
	a_fs_off: assert property (p_fs_off) else $error("fail-safe outputs wrong");
	property p_restart_rst; mode_o == SBCMS_RESTART |-> !reset_output_low_active_o; endproperty
	a_restart_rst: assert property (p_restart_rst) else $error("reset released in restart");
	// Leaving restart lands in normal with reset released, unless heat forces fail-safe
	sequence s_left_restart; mode_o == SBCMS_RESTART ##1 mode_o != SBCMS_RESTART; endsequence
	property p_restart_exit;
		s_left_restart |-> (mode_o == SBCMS_NORMAL && reset_output_low_active_o) || mode_o == SBCMS_FAILSAFE;
	endproperty
	a_restart_exit: assert property (p_restart_exit) else $error("bad restart exit");
	property p_dev_outs; $past(can_force_normal_o) && can_force_normal_o |-> wd_halt_o && aux_regulator_output_en_o; endproperty
	a_dev_outs: assert property (p_dev_outs) else $error("development outputs wrong");
	// Pull-down may trail the reset rise by one register stage only
	property p_pd_window; interrupt_config_pin_pd_o |-> !(reset_output_low_active_o && $past(reset_output_low_active_o)); endproperty
	a_pd_window: assert property (p_pd_window) else $error("pull-down outside reset");
	property p_cfg_hold; $changed(config_pin_state_o) |-> $rose(reset_output_low_active_o); endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed between latches");
	property p_one_mode; mode_o != 3'h4 && mode_o != 3'h5; endproperty
	a_one_mode: assert property (p_one_mode) else $error("illegal mode code");
	c_sleep: cover property (mode_o == SBCMS_SLEEP);
	c_failsafe: cover property (mode_o == SBCMS_FAILSAFE);
	c_cfg_one: cover property ($rose(config_pin_state_o));
endmodule
bind sbcms_top sbcms_top_asserts sbcms_top_asserts_inst (
	.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_ack_o(wb_ack_o), .mode_o(mode_o),
	.main_regulator_output_en_o(main_regulator_output_en_o), .reset_output_low_active_o(reset_output_low_active_o),
	.wd_long_window_start_o(wd_long_window_start_o), .wd_halt_o(wd_halt_o), .can_force_normal_o(can_force_normal_o),
	.aux_regulator_output_en_o(aux_regulator_output_en_o), .interrupt_config_pin_pd_o(interrupt_config_pin_pd_o),
	.config_pin_state_o(config_pin_state_o));
`default_nettype wire

// ---- dv/sbcms_board_model.sv ----
// Board model of the interrupt pin: optional pull-up, weak pull-down, floating level
`timescale 1ns/1ps
`default_nettype none
module sbcms_board_model (
	// Clock for the floating pattern
	input  wire logic clk_i,
	// Board and device drive
	input  wire logic pullup_present_i,
	input  wire logic pd_en_i,
	// Resolved pin level
	output logic      pin_o
);
	// ****************
	// Pin resolution
	// ****************
	logic float_r = 1'h0;
	// An undriven pin wanders so it never looks stable to the filter
	always_ff @(posedge clk_i) begin
		float_r <= ~float_r;
	end
	// Strong pull-up outweighs the weak internal pull-down
	assign pin_o = pullup_present_i ? 1'h1 : (pd_en_i ? 1'h0 : float_r);
endmodule
`default_nettype wire

// ---- dv/sbcms_top_tb.sv ----
// Self-checking bench for the mode sequencer and configuration capture
`timescale 1ns/1ps
`default_nettype none
module sbcms_top_tb;
	import sbcms_pkg::*;
	// ****************
	// Signals and instances
	// ****************
	localparam int RD = 20;
	logic        clk_sys_i = 1'h0, arst_n_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic        uv = 1'h1, wdf = 1'h0, cw = 1'h0, gw = 1'h0, tp = 1'h0, pu = 1'h1;
	logic        wb_ack_o, pin, pd, rst_o, reg_o, aux, canf, wds, wdh, fail, cfg;
	logic [2:0]  mode;
	int          num_errors = 0, checked = 0, cycles = 0, n;
	sbcms_top #(.RD_CYCLES(RD)) sbcms_top_inst (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .main_supply_undervolt_i(uv),
		.main_supply_warning_i(1'h0), .battery_undervolt_i(1'h0), .overvolt_i(1'h0),
		.overtemp_i(1'h0), .wd_fail_i(wdf), .can_wake_i(cw), .wake_sense_input_i(1'h0),
		.gpio_wake_i(gw), .test_pin_i(tp), .interrupt_config_pin_i(pin),
		.interrupt_config_pin_pd_o(pd), .reset_output_low_active_o(rst_o),
		.main_regulator_output_en_o(reg_o), .aux_regulator_output_en_o(aux),
		.can_force_normal_o(canf), .wd_long_window_start_o(wds), .wd_halt_o(wdh),
		.fail_output_o(fail), .mode_o(mode), .config_pin_state_o(cfg));
	sbcms_board_model sbcms_board_model_inst (.clk_i(clk_sys_i), .pullup_present_i(pu), .pd_en_i(pd), .pin_o(pin));
	// Clock and hang guard; a full run needs about 2000 cycles
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Classic cycle: hold until ack is sampled, take data there, then idle a cycle
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_sys_i);
		while (wb_ack_o !== 1'h1) begin
			@(posedge clk_sys_i);
			k++;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
		@(posedge clk_sys_i);
		chk(32'(k), 32'h1);
	endtask
	task automatic pulse(input int k);
		case (k)
			0: wdf <= 1'h1;
			1: cw <= 1'h1;
			default: gw <= 1'h1;
		endcase
		@(posedge clk_sys_i);
		{wdf, cw, gw} <= 3'h0;
		@(posedge clk_sys_i);
	endtask
	task automatic wait_mode(input logic [2:0] m);
		n = 0;
		while (mode !== m && n < 100) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk(mode, m);
	endtask
	// Long undervoltage so the filter settles on the pin level during reset
	task automatic uv_restart(input logic p, input logic epd);
		pu <= p;
		uv <= 1'h1;
		repeat (600) @(posedge clk_sys_i);
		chk(mode, SBCMS_RESTART);
		chk(pd, epd);
		uv <= 1'h0;
		wait_mode(SBCMS_NORMAL);
		chk(32'(n >= RD), 32'h1);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_power();
		repeat (600) @(posedge clk_sys_i);
		chk(pd, 1'h1);
		chk(rst_o, 1'h0);
		uv <= 1'h0;
		n = 0;
		while (rst_o !== 1'h1 && n < 100) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk(32'(n >= RD), 32'h1);
		chk(wds, 1'h1);
		chk(cfg, 1'h1);
		chk(mode, SBCMS_INIT);
		wb(1'h0, ADR_STATUS, 32'h0);
		chk(q[6:4], 3'h5);
		chk(mode, SBCMS_NORMAL);
		wb(1'h0, 8'h10, 32'h0);
		chk(q, 32'h0);
		$display("t_power done");
	endtask
	task automatic t_sleep();
		wb(1'h1, ADR_MODE_CTRL, 32'(MREQ_STOP));
		chk(mode, SBCMS_STOP);
		chk(reg_o, 1'h1);
		wb(1'h1, ADR_MODE_CTRL, 32'(MREQ_SLEEP));
		chk(mode, SBCMS_SLEEP);
		chk(reg_o, 1'h0);
		pulse(1);
		chk(mode, SBCMS_RESTART);
		wait_mode(SBCMS_NORMAL);
		chk(32'(n >= RD - 2), 32'h1);
		wb(1'h0, ADR_MODE_CTRL, 32'h0);
		chk(q, 32'h0);
		$display("t_sleep done");
	endtask
	task automatic t_wd();
		pulse(0);
		chk(mode, SBCMS_RESTART);
		wait_mode(SBCMS_NORMAL);
		chk(fail, 1'h0);
		pulse(0);
		chk(mode, SBCMS_RESTART);
		wait_mode(SBCMS_NORMAL);
		chk(fail, 1'h1);
		wb(1'h1, ADR_FLAGS, 32'h10);
		chk(fail, 1'h0);
		$display("t_wd done");
	endtask
	task automatic t_latch();
		uv_restart(1'h0, 1'h1);
		chk(cfg, 1'h0);
		wb(1'h1, ADR_FLAGS, 32'h1);
		uv_restart(1'h1, 1'h0);
		chk(cfg, 1'h0);
		$display("t_latch done");
	endtask
	task automatic t_fs();
		wb(1'h1, ADR_HW_CTRL, 32'h1);
		pulse(0);
		chk(mode, SBCMS_FAILSAFE);
		repeat (3) @(posedge clk_sys_i);
		chk({reg_o, rst_o, fail}, 3'h1);
		pulse(2);
		chk(mode, SBCMS_RESTART);
		wait_mode(SBCMS_NORMAL);
		wb(1'h0, ADR_HW_CTRL, 32'h0);
		chk(q[0], 1'h1);
		$display("t_fs done");
	endtask
	task automatic t_dev();
		tp <= 1'h1;
		wb(1'h1, ADR_MODE_CTRL, 32'(MREQ_SOFTRST));
		repeat (2) @(posedge clk_sys_i);
		chk(mode, SBCMS_INIT);
		chk({wdh, canf, aux}, 3'h7);
		wb(1'h0, ADR_HW_CTRL, 32'h0);
		chk(q[0], 1'h0);
		chk(mode, SBCMS_NORMAL);
		pulse(0);
		chk(mode, SBCMS_NORMAL);
		wb(1'h1, ADR_MODE_CTRL, 32'(MREQ_STOP));
		chk(mode, SBCMS_STOP);
		$display("t_dev done");
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		arst_n_i <= 1'h1;
		t_power();
		t_sleep();
		t_wd();
		t_latch();
		t_fs();
		t_dev();
		conclude();
	end
endmodule
`default_nettype wire
